//--- rtl/skip_exec_unit.sv
/*
  Execution unit for bit-test-and-skip, AND-with-file and watchdog clear,
  with its own watchdog counter and an AHB-Lite register slave.
  Assumes the register file answers file_rdata_in combinationally for
  file_raddr_out, and all core inputs share core_clk_in.
*/
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Bit tests take a 7-bit file address and a 3-bit bit index.
// - Skip-if-clear with bit one: next instruction runs, no flag change.
// - Skip-if-clear with bit zero: next instruction becomes a no-op.
// - Skip-if-set skips on one, runs next instruction on zero.
// - AND accumulator with file; dest 0 to accumulator, 1 to file; zero flag.
// - Watchdog clear zeroes the watchdog counter and its prescaler.
// - Watchdog clear sets expiry and sleep-entry flags, nothing else.
module skip_exec_unit import skip_exec_pkg::*; (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire op_req_t op_in,
  input wire logic [DATA_W-1:0] file_rdata_in,
  input wire logic sleep_req_in,
  output logic [FADDR_W-1:0] file_raddr_out,
  output file_wr_t file_wr_out,
  output logic discard_out,
  output logic timeout_out,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic [1:0] hresp_out,
  output logic [31:0] hrdata_out
);

  // ==========================================================
  // Core state
  // ==========================================================
  exec_state_t state_reg, state_next;
  logic [DATA_W-1:0] accum_reg, accum_next;
  logic zero_reg, zero_next;
  logic expiry_status_flag_reg, expiry_status_flag_next;
  logic sleep_entry_flag_reg, sleep_entry_flag_next;
  logic [PRESC_W-1:0] presc_reg, presc_next;
  logic [DATA_W-1:0] watchdog_counter_reg, watchdog_counter_next;
  logic timeout_reg, timeout_next;
  file_wr_t wr_reg, wr_next;
  logic wdog_en_reg, wdog_en_next;
  logic acc_wr_stb;
  logic [DATA_W-1:0] acc_wr_val;
  logic run, sel_bit, and_res_zero;
  logic [DATA_W-1:0] and_res;

  assign run = op_in.valid && (state_reg == st_exec);
  assign file_raddr_out = op_in.faddr;
  assign sel_bit = file_rdata_in[op_in.bidx];
  assign and_res = accum_reg & file_rdata_in;
  assign and_res_zero = (and_res == BYTE_ZERO);
  assign discard_out = (state_reg == st_skip);
  assign file_wr_out = wr_reg;
  assign timeout_out = timeout_reg;

  always_comb begin
    state_next = st_exec;
    accum_next = accum_reg;
    zero_next = zero_reg;
    expiry_status_flag_next = expiry_status_flag_reg;
    sleep_entry_flag_next = sleep_entry_flag_reg;
    presc_next = presc_reg;
    watchdog_counter_next = watchdog_counter_reg;
    timeout_next = 1'b0;
    wr_next = '0;
    if (acc_wr_stb) begin
      accum_next = acc_wr_val;
    end
    // Free-running watchdog; timeout drops the expiry flag
    if (wdog_en_reg) begin
      presc_next = presc_reg + 1'b1;
      if (presc_reg == PRESC_LAST) begin
        watchdog_counter_next = watchdog_counter_reg + 1'b1;
        if (watchdog_counter_reg == WDOG_LAST) begin
          timeout_next = 1'b1;
          expiry_status_flag_next = 1'b0;
        end
      end
    end
    if (sleep_req_in) begin
      sleep_entry_flag_next = 1'b0;
    end
    // Executed op comes last so its set wins over clears
    if (run) begin
      case (op_in.code)
        op_bit_test_skip_if_clear: begin
          if (!sel_bit) begin
            state_next = st_skip;
          end
        end
        op_bit_test_skip_if_set: begin
          if (sel_bit) begin
            state_next = st_skip;
          end
        end
        op_and_accum_with_file: begin
          zero_next = and_res_zero;
          if (op_in.dest) begin
            wr_next.en = 1'b1;
            wr_next.addr = op_in.faddr;
            wr_next.data = and_res;
          end else begin
            accum_next = and_res;
          end
        end
        op_watchdog_clear_op: begin
          presc_next = PRESC_ZERO;
          watchdog_counter_next = BYTE_ZERO;
          timeout_next = 1'b0;
          expiry_status_flag_next = 1'b1;
          sleep_entry_flag_next = 1'b1;
        end
        default: begin
          state_next = st_exec;
        end
      endcase
    end
  end

  // ==========================================================
  // AHB-Lite slave
  // ==========================================================
  logic dph_wr_reg, dph_wr_next;
  logic [7:0] dph_addr_reg, dph_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic addr_ok;
  logic [31:0] stat_word;

  assign addr_ok = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);
  assign hreadyout_out = ce_in;
  assign hresp_out = HRESP_OKAY;
  assign hrdata_out = rdata_reg;
  assign acc_wr_stb = dph_wr_reg && (dph_addr_reg == ACCUM_OFS);
  assign acc_wr_val = hwdata_in[DATA_W-1:0];

  always_comb begin
    stat_word = '0;
    stat_word[STAT_ZERO_BIT] = zero_reg;
    stat_word[STAT_EXPIRY_BIT] = expiry_status_flag_reg;
    stat_word[STAT_SLEEP_BIT] = sleep_entry_flag_reg;
    stat_word[STAT_SKIP_BIT] = discard_out;
  end

  always_comb begin
    dph_wr_next = addr_ok && hwrite_in;
    dph_addr_next = haddr_in[7:0];
    rdata_next = '0;
    if (dph_wr_reg && (dph_addr_reg == CTRL_OFS)) begin
      wdog_en_next = hwdata_in[CTRL_WDOG_EN_BIT];
    end else begin
      wdog_en_next = wdog_en_reg;
    end
    if (addr_ok && !hwrite_in && (haddr_in[31:8] == 24'h000000)) begin
      case (haddr_in[7:0])
        CTRL_OFS: rdata_next[CTRL_WDOG_EN_BIT] = wdog_en_reg;
        STAT_OFS: rdata_next = stat_word;
        ACCUM_OFS: rdata_next[DATA_W-1:0] = accum_reg;
        WDOG_OFS: rdata_next[DATA_W-1:0] = watchdog_counter_reg;
        default: rdata_next = '0;
      endcase
    end
    if (haddr_in[31:8] != 24'h000000) begin
      dph_addr_next = 8'hFF;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= st_exec;
      accum_reg <= BYTE_ZERO;
      zero_reg <= 1'b0;
      expiry_status_flag_reg <= 1'b1;
      sleep_entry_flag_reg <= 1'b1;
      presc_reg <= PRESC_ZERO;
      watchdog_counter_reg <= BYTE_ZERO;
      timeout_reg <= 1'b0;
      wr_reg <= '0;
      wdog_en_reg <= 1'b0;
      dph_wr_reg <= 1'b0;
      dph_addr_reg <= 8'h00;
      rdata_reg <= 32'h00000000;
    end else if (ce_in) begin
      state_reg <= state_next;
      accum_reg <= accum_next;
      zero_reg <= zero_next;
      expiry_status_flag_reg <= expiry_status_flag_next;
      sleep_entry_flag_reg <= sleep_entry_flag_next;
      presc_reg <= presc_next;
      watchdog_counter_reg <= watchdog_counter_next;
      timeout_reg <= timeout_next;
      wr_reg <= wr_next;
      wdog_en_reg <= wdog_en_next;
      dph_wr_reg <= dph_wr_next;
      dph_addr_reg <= dph_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in || !ce_in);

  sequence s_run_op(op_code_t c);
    run && op_in.code == c;
  endsequence

  sequence s_nop_then_back;
    discard_out ##1 !discard_out;
  endsequence

  a_bit_index_read: assert property (
    s_run_op(op_bit_test_skip_if_clear) |=>
      discard_out != $past(file_rdata_in[op_in.bidx]))
    else $error("bit test reads wrong bit");
  a_clear_bit_runs: assert property (
    s_run_op(op_bit_test_skip_if_clear) ##0 sel_bit |=>
      !discard_out && $stable(zero_reg) && $stable(expiry_status_flag_reg))
    else $error("skip-if-clear skipped on one");
  a_clear_bit_skips: assert property (
    s_run_op(op_bit_test_skip_if_clear) ##0 !sel_bit |=> s_nop_then_back)
    else $error("skip-if-clear did not skip on zero");
  a_set_bit_skip: assert property (
    s_run_op(op_bit_test_skip_if_set) |=>
      discard_out == $past(file_rdata_in[op_in.bidx]))
    else $error("skip-if-set skip wrong");
  a_and_dest_select: assert property (
    s_run_op(op_and_accum_with_file) |=>
      zero_reg == ($past(and_res) == BYTE_ZERO)
      && (wr_reg.en == $past(op_in.dest))
      && ($past(op_in.dest) ? wr_reg.data == $past(and_res)
          : accum_reg == $past(and_res)))
    else $error("AND result or destination wrong");
  a_wdog_cleared: assert property (
    s_run_op(op_watchdog_clear_op) |=>
      watchdog_counter_reg == BYTE_ZERO && presc_reg == PRESC_ZERO)
    else $error("watchdog not cleared");
  a_wdog_flags_set: assert property (
    s_run_op(op_watchdog_clear_op) |=> expiry_status_flag_reg
      && sleep_entry_flag_reg && $stable(zero_reg) && !timeout_reg)
    else $error("watchdog clear flags wrong");
  a_single_cycle_op: assert property (
    run && (op_in.code == op_and_accum_with_file
      || op_in.code == op_watchdog_clear_op) |=> !discard_out)
    else $error("op took more than one cycle");

endmodule : skip_exec_unit

`default_nettype wire

//--- pkg/skip_exec_pkg.sv
/*
  Constants, types and register map for the bit-test/skip, AND-with-file
  and watchdog-clear execution unit.
  Assumes a core that presents one decoded instruction per cycle.
*/
package skip_exec_pkg;

  // ==========================================================
  // Instruction fields
  // ==========================================================
  localparam int FADDR_W = 7;
  localparam int BIDX_W = 3;
  localparam int DATA_W = 8;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam int PRESC_W = 16;
  localparam logic [PRESC_W-1:0] PRESC_ZERO = 16'h0000;
  localparam logic [PRESC_W-1:0] PRESC_LAST = 16'hFFFF;
  localparam logic [DATA_W-1:0] WDOG_LAST = 8'hFF;

  typedef enum logic [2:0] {
    op_none,
    op_bit_test_skip_if_clear,
    op_bit_test_skip_if_set,
    op_and_accum_with_file,
    op_watchdog_clear_op,
    op_other
  } op_code_t;

  typedef struct packed {
    logic valid;
    op_code_t code;
    logic [FADDR_W-1:0] faddr;
    logic [BIDX_W-1:0] bidx;
    logic dest;
  } op_req_t;

  typedef struct packed {
    logic en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_wr_t;

  typedef enum logic {st_exec, st_skip} exec_state_t;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] ACCUM_OFS = 8'h08;
  localparam logic [7:0] WDOG_OFS = 8'h0C;
  localparam int CTRL_WDOG_EN_BIT = 0;
  localparam int STAT_ZERO_BIT = 0;
  localparam int STAT_EXPIRY_BIT = 1;
  localparam int STAT_SLEEP_BIT = 2;
  localparam int STAT_SKIP_BIT = 3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage : skip_exec_pkg

//--- tb/file_model.sv
/*
  Register file model on the far side of the execution unit.
  Assumes one clock; the bench loads the contents at time zero.
*/
`timescale 1ns/1ps
`default_nettype none
module file_model import skip_exec_pkg::*; (
  input wire logic core_clk_in,
  input wire logic [FADDR_W-1:0] raddr_in,
  input wire file_wr_t wr_in,
  output logic [DATA_W-1:0] rdata_out
);
  // ==========================================================
  // Storage
  // ==========================================================
  logic [DATA_W-1:0] mem [0:127];
  // Read port answers in the same cycle
  assign rdata_out = mem[raddr_in];
  always @(posedge core_clk_in) begin
    if (wr_in.en) begin
      mem[wr_in.addr] <= wr_in.data;
    end
  end
endmodule : file_model
`default_nettype wire

//--- tb/bit_skip_and_watchdog_clear_exec_test.sv
/*
  Self-checking bench for the skip, AND and watchdog-clear unit.
  Assumes the register file model beside it and a zero-wait AHB slave.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_skip_and_watchdog_clear_exec_test import skip_exec_pkg::*;;
  logic core_clk_in, reset_n_in, sleep_req_in, hsel_in, hwrite_in;
  op_req_t op_in;
  logic [1:0] htrans_in, hresp_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  logic hreadyout_out, discard_out, timeout_out, ce;
  logic [FADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;
  file_wr_t wr;
  int n_mismatch = 0;
  int num_checks = 0;

  skip_exec_unit u_skip_exec_unit (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .ce_in(ce), .op_in(op_in),
    .file_rdata_in(rdata), .sleep_req_in(sleep_req_in),
    .file_raddr_out(raddr), .file_wr_out(wr), .discard_out(discard_out),
    .timeout_out(timeout_out), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .hrdata_out(hrdata_out));
  file_model u_file_model (.core_clk_in(core_clk_in), .raddr_in(raddr),
    .wr_in(wr), .rdata_out(rdata));

  initial begin
    core_clk_in = 1'h0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] r);
    hsel_in <= 1'h1;
    haddr_in <= {24'h0, a};
    htrans_in <= HTRANS_NONSEQ;
    hwrite_in <= w;
    @(posedge core_clk_in);
    while (hreadyout_out !== 1'h1) @(posedge core_clk_in);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    @(posedge core_clk_in);
    while (hreadyout_out !== 1'h1) @(posedge core_clk_in);
    r = hrdata_out;
    chk(hresp_out, HRESP_OKAY);
  endtask : ahb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'h0, a, 32'h0, rd);
    chk(rd, e);
  endtask : rd_chk

  // Op is taken at the next edge and stays until the next call
  task automatic exec(input op_code_t c, input logic [6:0] a,
      input logic [2:0] b, input logic d);
    op_in <= '{1'h1, c, a, b, d};
    @(posedge core_clk_in);
  endtask : exec

  task automatic report_and_stop();
    $display("Checks: %0d, mismatches: %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    logic e;
    reset_n_in = 1'h0;
    sleep_req_in = 1'h0;
    ce = 1'h1;
    hsel_in = 1'h0;
    hwrite_in = 1'h0;
    htrans_in = 2'h0;
    haddr_in = 32'h0;
    hwdata_in = 32'h0;
    op_in = '0;
    for (int i = 0; i < 128; i++) u_file_model.mem[i] = 8'h00;
    u_file_model.mem[127] = 8'hA5;
    u_file_model.mem[5] = 8'h0F;
    u_file_model.mem[6] = 8'h30;
    u_file_model.mem[7] = 8'hC3;
    repeat (16) @(posedge core_clk_in);
    reset_n_in <= 1'h1;
    // Reset flags and counter, then an unmapped word
    rd_chk(STAT_OFS, 32'h6);
    rd_chk(WDOG_OFS, 32'h0);
    ahb(1'h1, 8'h40, 32'hFF, rd);
    rd_chk(8'h40, 32'h0);
    // Every bit of the top address, both tests; next op must be refused on a skip and run otherwise
    for (int s = 0; s < 2; s++) begin
      for (int b = 0; b < 8; b++) begin
        e = u_file_model.mem[127][b] ^ (s == 0);
        exec(s ? op_bit_test_skip_if_set : op_bit_test_skip_if_clear,
          7'h7F, b[2:0], 1'h0);
        // Outputs seen at the next edge show the previous op's effect
        exec(op_and_accum_with_file, 7'h10, 3'h0, 1'h1);
        chk(discard_out, e);
        exec(op_none, 7'h0, 3'h0, 1'h0);
        chk({discard_out, wr.en}, {1'h0, ~e});
      end
    end
    exec(op_none, 7'h0, 3'h0, 1'h0);
    ahb(1'h1, ACCUM_OFS, 32'h3C, rd);
    exec(op_and_accum_with_file, 7'h05, 3'h0, 1'h1);
    exec(op_and_accum_with_file, 7'h06, 3'h0, 1'h0);
    chk(wr, {1'h1, 7'h05, 8'h0C});
    exec(op_none, 7'h0, 3'h0, 1'h0);
    chk(wr.en, 1'h0);
    rd_chk(ACCUM_OFS, 32'h30);
    rd_chk(STAT_OFS, 32'h6);
    exec(op_and_accum_with_file, 7'h07, 3'h0, 1'h0);
    exec(op_none, 7'h0, 3'h0, 1'h0);
    rd_chk(ACCUM_OFS, 32'h0);
    rd_chk(STAT_OFS, 32'h7);
    // Clock enable low: a presented AND must not write
    ce <= 1'h0;
    exec(op_and_accum_with_file, 7'h05, 3'h0, 1'h1);
    chk(hreadyout_out, 1'h0);
    ce <= 1'h1;
    exec(op_none, 7'h0, 3'h0, 1'h0);
    chk(wr.en, 1'h0);
    // Clear just before the prescaler would wrap
    ahb(1'h1, CTRL_OFS, 32'h1, rd);
    sleep_req_in <= 1'h1;
    @(posedge core_clk_in);
    sleep_req_in <= 1'h0;
    rd_chk(STAT_OFS, 32'h3);
    repeat (65400) @(posedge core_clk_in);
    exec(op_watchdog_clear_op, 7'h0, 3'h0, 1'h0);
    exec(op_none, 7'h0, 3'h0, 1'h0);
    repeat (200) @(posedge core_clk_in);
    rd_chk(WDOG_OFS, 32'h0);
    rd_chk(STAT_OFS, 32'h7);
    report_and_stop();
  end

  initial begin
    #600000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : bit_skip_and_watchdog_clear_exec_test
`default_nettype wire
